// [rtl/erbri_pkg.sv]
// Shared constants, modes and carriers of the embedded RAM block.
package erbri_pkg;

    // Array geometry.
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int BE_W   = 4;
    localparam int DEPTH  = 256;
    localparam int PAD_W  = DATA_W - ADDR_W;
    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);

    // Register bus map.
    localparam int AXI_AW = 4;
    localparam logic [AXI_AW-1:0] OFF_CFG  = 4'h0;
    localparam logic [AXI_AW-1:0] OFF_STAT = 4'h4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Value returned by a mixed-port collision that has no defined answer.
    localparam logic [DATA_W-1:0] MIX_FILL = 32'h0000_0000;

    typedef enum logic [1:0] {MM_SINGLE, MM_SIMPLE, MM_TRUE, MM_RSVD} erbri_mem_e;
    typedef enum logic [1:0] {CK_SINGLE, CK_INOUT, CK_INDEP, CK_RDWR} erbri_clk_e;
    typedef enum logic [1:0] {SP_DONTCARE, SP_NEW, SP_OLD, SP_RSVD} erbri_same_e;
    typedef enum logic {MP_OLD, MP_DONTCARE} erbri_mixed_e;
    typedef enum logic [1:0] {IMG_SC_INIT, IMG_SU_INIT, IMG_SC, IMG_DUAL} erbri_img_e;
    typedef enum logic {ST_INIT, ST_RUN} erbri_state_e;

    // Configuration word, low bits of the configuration register.
    typedef struct packed {
        logic         out_reg;
        erbri_mixed_e mp;
        erbri_same_e  sp;
        erbri_clk_e   ck;
        erbri_mem_e   mm;
    } erbri_cfg_s;

    // Status word, low bits of the status register.
    typedef struct packed {
        logic a_seen;
        logic b_seen;
        logic preloaded;
        logic init_busy;
        logic cfg_ok;
    } erbri_stat_s;

    localparam int CFG_W  = $bits(erbri_cfg_s);
    localparam int STAT_W = $bits(erbri_stat_s);
    localparam erbri_cfg_s CFG_RST = '{1'b0, MP_OLD, SP_DONTCARE, CK_SINGLE, MM_SINGLE};

    // Tells whether a mode, clock arrangement and output choice may be combined.
    function automatic logic erbri_cfg_ok(erbri_cfg_s c);
        logic ck2;
        ck2 = (c.ck == CK_SINGLE) || (c.ck == CK_INOUT);
        case (c.mm)
            MM_SINGLE: erbri_cfg_ok = ck2 && (c.sp != SP_RSVD);
            MM_SIMPLE: erbri_cfg_ok = ck2;
            MM_TRUE:   erbri_cfg_ok = (ck2 || (c.ck == CK_INDEP))
                                      && ((c.sp == SP_NEW) || (c.sp == SP_OLD));
            default:   erbri_cfg_ok = 1'b0;
        endcase
    endfunction : erbri_cfg_ok

endpackage : erbri_pkg

// [rtl/erbri_top.sv]
// Embedded RAM block with read-during-write choices and an AXI4-Lite setup port.
// What the document requires of the block and the fabric
// R01: Read outputs are zero after power-up.
// R02: Preloaded data shows only after first read.
// R03: Array starts zero unless content supplied.
// R04: Preload only in single images with initialisation.
// R05: Fabric raises read enable only when needed.
// R06: Separate clock enables for inputs and outputs.
// R07: Single-port: same-port only, single or in/out clock.
// R08: Simple dual: mixed-port only, single or in/out clock.
// R09: True dual same-port: single, in/out, independent.
// R10: True dual mixed-port: never independent clocks.
// R11: Only listed output choices per mode.
// R12: Fabric prefers don't-care when output irrelevant.
// R13: Write data as wide as read output.
// R14: Store strobe and address select the word.
// R15: New-data passes written lanes, keeps masked ones.
// R16: Old-data mixed read returns pre-write value.
// R17: Address stall holds the registered address.
// R18: Write lands on edge with strobe and enable.
// R19: Fabric holds inputs stable around edges.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
module erbri_top #(
    parameter logic                  HAS_INIT_FILE = 1'b0,
    parameter erbri_pkg::erbri_img_e IMAGE_MODE    = erbri_pkg::IMG_SC_INIT,
    parameter logic [31:0]           INIT_SEED     = 32'h0000_0000
) (
    // Clock and reset.
    input  wire logic                            CORE_CLK,
    input  wire logic                            ARST_N,
    // AXI4-Lite register port.
    input  wire logic [erbri_pkg::AXI_AW-1:0]    S_AXI_AWADDR,
    input  wire logic                            S_AXI_AWVALID,
    output logic                                 S_AXI_AWREADY,
    input  wire logic [31:0]                     S_AXI_WDATA,
    input  wire logic [3:0]                      S_AXI_WSTRB,
    input  wire logic                            S_AXI_WVALID,
    output logic                                 S_AXI_WREADY,
    output logic [1:0]                           S_AXI_BRESP,
    output logic                                 S_AXI_BVALID,
    input  wire logic                            S_AXI_BREADY,
    input  wire logic [erbri_pkg::AXI_AW-1:0]    S_AXI_ARADDR,
    input  wire logic                            S_AXI_ARVALID,
    output logic                                 S_AXI_ARREADY,
    output logic [31:0]                          S_AXI_RDATA,
    output logic [1:0]                           S_AXI_RRESP,
    output logic                                 S_AXI_RVALID,
    input  wire logic                            S_AXI_RREADY,
    // Register group clock enables.
    input  wire logic                            IN_CE,
    input  wire logic                            OUT_CE,
    // Port A.
    input  wire logic [erbri_pkg::ADDR_W-1:0]    A_ADDR,
    input  wire logic [erbri_pkg::DATA_W-1:0]    A_DATA,
    input  wire logic                            A_WREN,
    input  wire logic [erbri_pkg::BE_W-1:0]      A_BYTEEN,
    input  wire logic                            A_RDEN,
    input  wire logic                            A_ADDR_STALL,
    output logic [erbri_pkg::DATA_W-1:0]         A_Q,
    // Port B.
    input  wire logic [erbri_pkg::ADDR_W-1:0]    B_ADDR,
    input  wire logic [erbri_pkg::DATA_W-1:0]    B_DATA,
    input  wire logic                            B_WREN,
    input  wire logic                            B_RDEN,
    output logic [erbri_pkg::DATA_W-1:0]         B_Q
);
    import erbri_pkg::*;
    logic [DATA_W-1:0] mem [DEPTH];
    erbri_state_e      st_q;
    logic [ADDR_W-1:0] init_addr_q;
    logic [ADDR_W-1:0] a_addr_q;
    logic [DATA_W-1:0] a_raw_q, b_raw_q, a_q_q, b_q_q;
    logic              a_seen_q, b_seen_q;
    erbri_cfg_s        cfg_q;
    logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_have_q, w_have_q;
    logic [AXI_AW-1:0] aw_q;
    logic [DATA_W-1:0] wdata_q, rdata_q;
    logic [BE_W-1:0]   wstrb_q;
    logic [1:0]        bresp_q, rresp_q;
    // Preloading needs both a content set and an image that carries it.
    localparam logic PRELOAD = HAS_INIT_FILE
        && ((IMAGE_MODE == IMG_SC_INIT) || (IMAGE_MODE == IMG_SU_INIT)); // see R04
    // Port qualification; a refused combination blocks every access.
    wire               run    = (st_q == ST_RUN);
    wire               ok     = erbri_cfg_ok(cfg_q); // see R07 see R08 see R09 see R11
    wire               go     = run && ok && IN_CE; // see R06
    wire               a_wr   = go && A_WREN; // see R14 see R18
    wire               a_rd   = go && A_RDEN && (cfg_q.mm != MM_SIMPLE); // see R05
    wire               b_wr   = go && B_WREN && (cfg_q.mm == MM_TRUE);
    wire               b_rd   = go && B_RDEN && (cfg_q.mm != MM_SINGLE);
    wire [ADDR_W-1:0]  a_addr = A_ADDR_STALL ? a_addr_q : A_ADDR; // see R17
    wire [DATA_W-1:0]  old_a  = mem[a_addr];
    wire [DATA_W-1:0]  old_b  = mem[B_ADDR];
    wire [DATA_W-1:0]  init_v = PRELOAD ? (INIT_SEED ^ {{PAD_W{1'b0}}, init_addr_q})
                                        : '0; // see R03
    logic [DATA_W-1:0] a_new;
    // Masked lanes keep the stored byte, which a new-data read then shows.
    for (genvar i = 0; i < BE_W; i++)
    begin : g_lane
        assign a_new[i*8 +: 8] = A_BYTEEN[i] ? A_DATA[i*8 +: 8] : old_a[i*8 +: 8]; // see R13
    end
    // Mixed-port collisions only have a defined answer on a shared clock.
    wire               mix_dc = (cfg_q.mp == MP_DONTCARE) || (cfg_q.ck == CK_INDEP); // see R10
    wire               a_mix  = b_wr && (B_ADDR == a_addr);
    wire               b_mix  = a_wr && (a_addr == B_ADDR);
    wire [DATA_W-1:0]  a_same = (a_wr && (cfg_q.sp == SP_NEW)) ? a_new : old_a; // see R15
    wire [DATA_W-1:0]  b_same = (b_wr && (cfg_q.sp == SP_NEW)) ? B_DATA : old_b;
    wire [DATA_W-1:0]  a_rd_d = (a_mix && mix_dc) ? MIX_FILL : a_same;
    wire [DATA_W-1:0]  b_rd_d = (b_mix && mix_dc) ? MIX_FILL : b_same; // see R16
    // Array writes; no reset, the start-up walk fills every word.
    always_ff @(posedge CORE_CLK)
    begin
        if (st_q == ST_INIT)
            mem[init_addr_q] <= init_v; // see R03
        else
        begin
            if (b_wr)
                mem[B_ADDR] <= B_DATA;
            if (a_wr)
                mem[a_addr] <= a_new; // see R18
        end
    end

    // Start-up walk; ports are refused until it ends.
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            st_q        <= ST_INIT;
            init_addr_q <= '0;
        end
        else if (st_q == ST_INIT)
        begin
            init_addr_q <= init_addr_q + 1'b1;
            if (init_addr_q == LAST_ADDR)
                st_q <= ST_RUN;
        end
    end

    // Address register; the stall keeps feeding back the held value.
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            a_addr_q <= '0;
        else if (IN_CE)
            a_addr_q <= a_addr; // see R17
    end

    // Read stages; outputs stay zero until the first read of each port.
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            a_raw_q  <= '0; // see R01
            b_raw_q  <= '0;
            a_seen_q <= 1'b0;
            b_seen_q <= 1'b0;
        end
        else
        begin
            if (a_rd)
                a_raw_q <= a_rd_d;
            if (b_rd)
                b_raw_q <= b_rd_d;
            a_seen_q <= a_seen_q | a_rd;
            b_seen_q <= b_seen_q | b_rd;
        end
    end

    // Output registers, or a bypass that loads at the read edge itself.
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            a_q_q <= '0; // see R01 see R02
            b_q_q <= '0;
        end
        else if (cfg_q.out_reg)
        begin
            if (OUT_CE)
            begin
                a_q_q <= a_raw_q; // see R06
                b_q_q <= b_raw_q;
            end
        end
        else
        begin
            if (a_rd)
                a_q_q <= a_rd_d; // see R02
            if (b_rd)
                b_q_q <= b_rd_d;
        end
    end

    // Register bus decode.
    wire               aw_hs  = S_AXI_AWVALID && awready_q;
    wire               w_hs   = S_AXI_WVALID && wready_q;
    wire               do_wr  = aw_have_q && w_have_q && !bvalid_q;
    wire               wr_hit = (aw_q == OFF_CFG) || (aw_q == OFF_STAT);
    wire               wr_cfg = do_wr && (aw_q == OFF_CFG) && wstrb_q[0];
    wire               ar_hs  = S_AXI_ARVALID && arready_q;
    wire               rd_hit = (S_AXI_ARADDR == OFF_CFG) || (S_AXI_ARADDR == OFF_STAT);
    wire erbri_stat_s  stat   = '{a_seen_q, b_seen_q, PRELOAD, !run, ok};
    wire [DATA_W-1:0]  rd_mux = (S_AXI_ARADDR == OFF_CFG) ? {{(DATA_W-CFG_W){1'b0}}, cfg_q}
                              : (S_AXI_ARADDR == OFF_STAT) ? {{(DATA_W-STAT_W){1'b0}}, stat}
                              : '0;

    // Write channel: address and data taken in either order, one at a time.
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            aw_q      <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_q      <= S_AXI_AWADDR;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (w_hs)
            begin
                wdata_q  <= S_AXI_WDATA;
                wstrb_q  <= S_AXI_WSTRB;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (do_wr)
            begin
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
            if (bvalid_q && S_AXI_BREADY)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // Configuration register; a change acts from the next edge on.
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            cfg_q <= CFG_RST;
        else if (wr_cfg)
            cfg_q <= erbri_cfg_s'(wdata_q[CFG_W-1:0]);
    end

    // Read channel; the answer is loaded at the address handshake.
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_mux;
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && S_AXI_RREADY)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
        end
    end
    // Every output is driven straight from its own flip-flop.
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY  = wready_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;
    assign A_Q           = a_q_q;
    assign B_Q           = b_q_q;
    // Checks on the datapath, all on the core clock.
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);
    sequence s_new_rdw;
        a_rd && a_wr && (cfg_q.sp == SP_NEW) && !cfg_q.out_reg && !a_mix;
    endsequence
    sequence s_old_mix;
        b_rd && b_mix && !b_wr && !mix_dc && !cfg_q.out_reg; // A double write is undefined.
    endsequence
    a_out_zero_init:  assert property (!run |-> (A_Q == '0) && (B_Q == '0)) // see R01
        else $error("read output not zero during start-up");
    a_first_read:     assert property (!a_seen_q && !a_rd |=> (A_Q == '0)) // see R02
        else $error("port A output moved before its first read");
    a_init_fill:      assert property (!run |=> mem[$past(init_addr_q)] == // see R03
                          (PRELOAD ? (INIT_SEED ^ {{PAD_W{1'b0}}, $past(init_addr_q)}) : '0))
        else $error("start-up walk wrote wrong content");
    a_single_clock:   assert property ((cfg_q.mm == MM_SINGLE) && cfg_q.ck[1] |-> !go) // see R07
        else $error("single-port access with a refused clock arrangement");
    a_simple_clock:   assert property ((cfg_q.mm == MM_SIMPLE) && cfg_q.ck[1] |-> !go) // see R08
        else $error("simple dual-port access with a refused clock arrangement");
    a_true_indep:     assert property (run && IN_CE && A_WREN && (cfg_q.mm == MM_TRUE) // see R09
                          && (cfg_q.ck == CK_INDEP) && (cfg_q.sp == SP_OLD) |-> a_wr)
        else $error("true dual-port write refused on independent clocks");
    a_indep_mixed:    assert property (b_rd && b_mix && (cfg_q.ck == CK_INDEP) // see R10
                          && !cfg_q.out_reg |=> (B_Q == MIX_FILL))
        else $error("independent-clock mixed collision not filled");
    a_true_choice:    assert property ((cfg_q.mm == MM_TRUE) // see R11
                          && (cfg_q.sp == SP_DONTCARE) |-> !ok)
        else $error("true dual-port accepted a don't-care same-port choice");
    a_new_data:       assert property (s_new_rdw |=> (A_Q == $past(a_new))) // see R15
        else $error("new-data read did not show written lanes");
    a_old_mixed:      assert property (s_old_mix |=> (B_Q == $past(old_b))) // see R16
        else $error("old-data mixed read did not return prior value");
    a_addr_stall:     assert property (A_ADDR_STALL && IN_CE |=> $stable(a_addr_q)) // see R17
        else $error("address moved while stalled");
    a_write_lands:    assert property (a_wr && !a_mix ##0 (A_BYTEEN == '1) // see R18
                          |=> mem[$past(a_addr)] == $past(A_DATA))
        else $error("write did not land on its edge");
    a_out_hold:       assert property (cfg_q.out_reg && !OUT_CE |=> $stable(A_Q)) // see R06
        else $error("output register moved without its clock enable");
endmodule : erbri_top

// [tb/erbri_fabric.sv]
// Fabric-side model that drives the two RAM ports.
module erbri_fabric (
    // Clock.
    input  wire logic                       clk,
    // Port A.
    output logic [erbri_pkg::ADDR_W-1:0]    a_addr,
    output logic [erbri_pkg::DATA_W-1:0]    a_data,
    output logic                            a_wren,
    output logic [erbri_pkg::BE_W-1:0]      a_be,
    output logic                            a_rden,
    output logic                            a_stall,
    // Port B.
    output logic [erbri_pkg::ADDR_W-1:0]    b_addr,
    output logic [erbri_pkg::DATA_W-1:0]    b_data,
    output logic                            b_wren,
    output logic                            b_rden
);
    timeunit 1ns;
    timeprecision 1ns;
    import erbri_pkg::*;

    // Idle ports at time zero.
    initial
    begin
        {a_addr, a_data, a_wren, a_be, a_rden, a_stall} = '0;
        {b_addr, b_data, b_wren, b_rden} = '0;
    end

    // One port cycle; the request stands a whole clock and is dropped at the taking edge.
    // Released data lines flip, so a stale value can never pass for a fresh one.
    task automatic cyc(input logic [ADDR_W-1:0] aa, input logic [DATA_W-1:0] ad,
                       input logic aw, input logic [BE_W-1:0] ab, input logic ar,
                       input logic as = 1'h0, input logic [ADDR_W-1:0] ba = 8'h0,
                       input logic [DATA_W-1:0] bd = 32'h0, input logic bw = 1'h0,
                       input logic br = 1'h0);
        @(posedge clk);
        a_addr  <= aa;
        a_data  <= ad;
        a_wren  <= aw;
        a_be    <= ab;
        a_rden  <= ar;
        a_stall <= as;
        b_addr  <= ba;
        b_data  <= bd;
        b_wren  <= bw;
        b_rden  <= br;
        @(posedge clk);
        a_wren  <= 1'h0;
        a_rden  <= 1'h0;
        b_wren  <= 1'h0;
        b_rden  <= 1'h0;
        a_stall <= 1'h0;
        a_data  <= ~ad;
        b_data  <= ~bd;
        a_be    <= ~ab;
        #1;
    endtask : cyc

endmodule : erbri_fabric

// [tb/erbri_tb_top.sv]
// Self-checking bench for the embedded RAM block.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define FAB erbri_fabric_inst.cyc
module erbri_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import erbri_pkg::*;
    localparam logic [31:0] SEED = 32'h5A00_00C3;
    typedef struct {logic [7:0] cfg; logic ok;} erbri_row_s;
    logic              clk = 1'h0;
    logic              arst_n = 1'h0;
    logic              awvalid, wvalid, bready, arvalid, rready, in_ce, out_ce;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [3:0]        awaddr, araddr, wstrb;
    logic [31:0]       wdata, rdata, a_q, b_q, d;
    logic [1:0]        bresp, rresp, r;
    logic [ADDR_W-1:0] a_addr, b_addr;
    logic [DATA_W-1:0] a_data, b_data;
    logic [BE_W-1:0]   a_be;
    logic              a_wren, a_rden, a_stall, b_wren, b_rden;
    int                n_errors = 0;
    int                n_tests = 0;
    // Mode, clock and output-choice words beside their expected legality.
    erbri_row_s rows[11] = '{'{8'h00, 1'h1}, '{8'h14, 1'h1}, '{8'h28, 1'h0}, '{8'h30, 1'h0},
        '{8'h05, 1'h1}, '{8'h49, 1'h0}, '{8'h1A, 1'h1}, '{8'h02, 1'h0}, '{8'h26, 1'h1},
        '{8'h03, 1'h0}, '{8'h0C, 1'h0}};

    // A 100 ns clock.
    always #50 clk = ~clk;

    // Device under test, with a preload image so start-up contents are visible.
    erbri_top #(.HAS_INIT_FILE(1'h1), .IMAGE_MODE(IMG_SC_INIT), .INIT_SEED(SEED)) erbri_top_inst (
        .CORE_CLK(clk), .ARST_N(arst_n), .IN_CE(in_ce), .OUT_CE(out_ce),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .A_ADDR(a_addr), .A_DATA(a_data), .A_WREN(a_wren), .A_BYTEEN(a_be),
        .A_RDEN(a_rden), .A_ADDR_STALL(a_stall), .A_Q(a_q),
        .B_ADDR(b_addr), .B_DATA(b_data), .B_WREN(b_wren), .B_RDEN(b_rden), .B_Q(b_q));

    // Fabric model on the far side.
    erbri_fabric erbri_fabric_inst (
        .clk(clk), .a_addr(a_addr), .a_data(a_data), .a_wren(a_wren), .a_be(a_be),
        .a_rden(a_rden), .a_stall(a_stall), .b_addr(b_addr), .b_data(b_data),
        .b_wren(b_wren), .b_rden(b_rden));

    // Register write; address and data offered together, each dropped when taken.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw_p;
        logic w_p;
        aw_p = 1'h1;
        w_p = 1'h1;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= v;
        wstrb <= 4'hF;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (aw_p || w_p)
        begin
            @(posedge clk);
            aw_p = aw_p && !awready;
            w_p = w_p && !wready;
            awvalid <= aw_p;
            wvalid <= w_p;
        end
        do @(posedge clk); while (!bvalid);
        rs = bresp;
        bready <= 1'h0;
    endtask : axi_wr

    // Register read; the address is held until taken, the answer until seen.
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge clk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask : axi_rd

    // Reset, look at the cleared outputs, then wait out the start-up walk.
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'h0;
        repeat (20) @(posedge clk);
        `CHK(a_q, 32'h0)
        `CHK(b_q, 32'h0)
        arst_n <= 1'h1;
        d = 32'h2;
        while (d[1]) axi_rd(OFF_STAT, d, r);
        `CHK(d[4:0], 5'h05)
        `CHK(a_q, 32'h0)
        $display("test done: reset");
    endtask : do_reset

    // Verdict and end of run.
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // Main sequence.
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wstrb, wdata} = '0;
        in_ce = 1'h1;
        out_ce = 1'h1;
        do_reset();
        `FAB(8'h3, 32'h0, 1'h0, 4'h0, 1'h1);
        `CHK(a_q, SEED ^ 32'h3)
        foreach (rows[i])
        begin
            axi_wr(OFF_CFG, {24'h0, rows[i].cfg}, r);
            axi_rd(OFF_CFG, d, r);
            `CHK(d[7:0], rows[i].cfg)
            axi_rd(OFF_STAT, d, r);
            `CHK(d[0], rows[i].ok)
        end
        // The last row is illegal, so this write must be refused.
        `FAB(8'h9, 32'h0BAD_0009, 1'h1, 4'hF, 1'h1);
        axi_wr(OFF_CFG, 32'h10, r);
        `FAB(8'h9, 32'h0, 1'h0, 4'h0, 1'h1);
        `CHK(a_q, SEED ^ 32'h9)
        $display("test done: mode table");
        `FAB(8'h5, 32'h1122_3344, 1'h1, 4'hF, 1'h1);
        `CHK(a_q, 32'h1122_3344)
        `FAB(8'h5, 32'hAABB_CCDD, 1'h1, 4'h5, 1'h1);
        `CHK(a_q, 32'h11BB_33DD)
        `FAB(8'h5, 32'hFFFF_FFFF, 1'h0, 4'hF, 1'h1);
        `CHK(a_q, 32'h11BB_33DD)
        @(posedge clk);
        in_ce <= 1'h0;
        `FAB(8'h5, 32'h0, 1'h1, 4'hF, 1'h1);
        `CHK(a_q, 32'h11BB_33DD)
        @(posedge clk);
        in_ce <= 1'h1;
        `FAB(8'h6, 32'h0, 1'h0, 4'h0, 1'h1, 1'h1);
        `CHK(a_q, 32'h11BB_33DD)
        axi_wr(OFF_CFG, 32'h20, r);
        `FAB(8'h5, 32'h0000_1111, 1'h1, 4'hF, 1'h1);
        `CHK(a_q, 32'h11BB_33DD)
        $display("test done: same port");
        // Output stage: two edges to show, frozen while its enable is low.
        axi_wr(OFF_CFG, 32'hA0, r);
        `FAB(8'h5, 32'h0, 1'h0, 4'h0, 1'h1);
        @(posedge clk);
        out_ce <= 1'h0;
        #1;
        `CHK(a_q, 32'h0000_1111)
        `FAB(8'h3, 32'h0, 1'h0, 4'h0, 1'h1);
        repeat (2) @(posedge clk);
        out_ce <= 1'h1;
        #1;
        `CHK(a_q, 32'h0000_1111)
        @(posedge clk);
        #1;
        `CHK(a_q, SEED ^ 32'h3)
        $display("test done: output stage");
        axi_wr(OFF_CFG, 32'h01, r);
        `FAB(8'h7, 32'hCAFE_0007, 1'h1, 4'hF, 1'h0, 1'h0, 8'h7, 32'h0, 1'h0, 1'h1);
        `CHK(b_q, SEED ^ 32'h7)
        `FAB(8'h0, 32'h0, 1'h0, 4'h0, 1'h0, 1'h0, 8'h7, 32'h0, 1'h0, 1'h1);
        `CHK(b_q, 32'hCAFE_0007)
        axi_wr(OFF_CFG, 32'h1A, r);
        `FAB(8'h8, 32'h0000_8888, 1'h1, 4'hF, 1'h1, 1'h0, 8'h8, 32'h0, 1'h0, 1'h1);
        `CHK(a_q, 32'h0000_8888)
        `CHK(b_q, MIX_FILL)
        `FAB(8'hA, 32'h0, 1'h0, 4'h0, 1'h0, 1'h0, 8'hA, 32'h0000_BBBB, 1'h1, 1'h0);
        `FAB(8'hA, 32'h0, 1'h0, 4'h0, 1'h1);
        `CHK(a_q, 32'h0000_BBBB)
        axi_wr(OFF_CFG, 32'h22, r);
        `FAB(8'h8, 32'h0000_9999, 1'h1, 4'hF, 1'h0, 1'h0, 8'h8, 32'h0, 1'h0, 1'h1);
        `CHK(b_q, 32'h0000_8888)
        // Don't-care choices, used where the collision answer is not needed.
        axi_wr(OFF_CFG, 32'h41, r);
        `FAB(8'h7, 32'h0000_7777, 1'h1, 4'hF, 1'h0, 1'h0, 8'h7, 32'h0, 1'h0, 1'h1);
        `CHK(b_q, MIX_FILL)
        axi_wr(OFF_CFG, 32'h00, r);
        `FAB(8'h7, 32'h0000_1234, 1'h1, 4'hF, 1'h1);
        `CHK(a_q, 32'h0000_7777)
        $display("test done: mixed port");
        // Unmapped places answer with an error; the status word ignores writes.
        axi_rd(4'h8, d, r);
        `CHK(r, RESP_SLVERR)
        `CHK(d, 32'h0)
        axi_wr(4'hC, 32'h1, r);
        `CHK(r, RESP_SLVERR)
        axi_wr(OFF_STAT, 32'h0, r);
        `CHK(r, RESP_OKAY)
        $display("test done: register bus");
        do_reset();
        `FAB(8'h5, 32'h0, 1'h0, 4'h0, 1'h1);
        `CHK(a_q, SEED ^ 32'h5)
        complete_run();
    end

    // Watchdog; the whole run needs about a thousand cycles.
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end

endmodule : erbri_tb_top
